//--- include/cpi_regs.svh
// constants of the configuration pin block: scheme straps and timing
// assumes a 100 MHz system clock; included by its bare name
`ifndef CPI_REGS_SVH
`define CPI_REGS_SVH

// scheme strap codes on the two select pins
`define CPI_SCH_PS          2'h0
`define CPI_SCH_FPP         2'h1
`define CPI_SCH_AS          2'h2
`define CPI_SCH_AP          2'h3

// system clock period and driven config clock half period, in ns
`define CPI_SYS_PERIOD_NS   10
`define CPI_CLK_HALF_NS     20
// least half period rounds up to whole system cycles
`define CPI_CLK_HALF_CYC    ((`CPI_CLK_HALF_NS + `CPI_SYS_PERIOD_NS - 1) \
                             / `CPI_SYS_PERIOD_NS)

// cycles to let strap synchronisers settle before latching
`define CPI_STRAP_WAIT      2'h3

// serial memory read request: opcode, start address, bit count
`define CPI_AS_READ_CMD     8'h03
`define CPI_AS_START_ADDR   24'h000000
`define CPI_AS_CMD_BITS     6'h20

// reset values of driven pins
`define CPI_CLK_IDLE        1'h0
`define CPI_CMD_IDLE        1'h1

`endif

//--- include/cpi_pkg.sv
// types of the configuration pin block
// assumes cpi_regs.svh carries the numeric constants
package cpi_pkg;

    // loader sequence of the system-clock side
    typedef enum logic [2:0] {
        ST_STRAP,
        ST_IDLE,
        ST_CMD,
        ST_RECV,
        ST_USER
    } cpi_state_t;

    typedef logic [1:0] cpi_scheme_t;

endpackage : cpi_pkg

//--- include/cpi_link_if.sv
// carrier of one captured byte from the link domain to the system domain
// assumes the byte is held stable from one toggle to the next
`timescale 1ns/1ns
interface cpi_link_if;
    logic [7:0] byteHold;   // last complete byte
    logic       byteTgl;    // flips once per new byte

    modport cap (output byteHold, output byteTgl);
    modport sys (input byteHold, input byteTgl);
endinterface : cpi_link_if

//--- hdl/cpi_sync.sv
// two flip-flop level synchroniser, one chain per bit
// assumes inputs are quasi-static levels from another domain or a pin
`timescale 1ns/1ns
module cpi_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    // first stage feeds only the second stage
    genvar i;
    for (i = 0; i < WIDTH; i++) begin : g_bit
        logic meta_r;
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                meta_r <= 1'h0;
                q[i]   <= 1'h0;
            end else begin
                meta_r <= d[i];
                q[i]   <= meta_r;
            end
        end
    end

endmodule : cpi_sync

//--- hdl/cpi_link_capture.sv
// passive-scheme capture running on the host-driven config clock
// assumes the host clock may stop between bytes; no edge is counted on
`timescale 1ns/1ns
module cpi_link_capture (
    input  wire logic       linkClk,
    input  wire logic       rst,
    input  wire logic       fppMode,
    input  wire logic [7:0] dataPin,
    cpi_link_if.cap         lnk
);

    logic       fppSync;
    logic [6:0] shift_r;
    logic [2:0] bitCnt_r;

    // scheme level is static long before the first host edge
    cpi_sync #(.WIDTH(1)) u_modeSync (
        .clk (linkClk),
        .rst (rst),
        .d   (fppMode),
        .q   (fppSync)
    );

    // sample on the rising host edge: a byte per edge or a bit per edge
    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            shift_r      <= 7'h00;
            bitCnt_r     <= 3'h0;
            lnk.byteHold <= 8'h00;
            lnk.byteTgl  <= 1'h0;
        end else if (fppSync) begin
            lnk.byteHold <= dataPin;
            lnk.byteTgl  <= ~lnk.byteTgl;
        end else begin
            shift_r  <= {dataPin[0], shift_r[6:1]};
            bitCnt_r <= bitCnt_r + 3'h1;
            if (bitCnt_r == 3'h7) begin
                lnk.byteHold <= {dataPin[0], shift_r};
                lnk.byteTgl  <= ~lnk.byteTgl;
            end
        end
    end

endmodule : cpi_link_capture

//--- hdl/cpi_config_pins.sv
// configuration pin block: config clock, data pins, user reuse of the data pins and, in the active schemes, of the clock
// assumes pins are split into in/out/enable by the pad ring and a
// configuration controller outside asserts cfgComplete
`timescale 1ns/1ns
`include "cpi_regs.svh"
module cpi_config_pins (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        cfgClkIn,
    output logic             cfgClkOut,
    output logic             cfgClkOe_n,
    input  wire logic [15:0] dataIn,
    output logic      [15:0] dataOut,
    output logic      [15:0] dataOe_n,
    input  wire logic        chipEnable_n,
    input  wire logic [1:0]  schemeSel,
    input  wire logic        apWide,
    input  wire logic        cfgComplete,
    input  wire logic        userClkEn,
    input  wire logic        userClkOut,
    input  wire logic        userClkOe_n,
    input  wire logic [15:0] userDataOut,
    input  wire logic [15:0] userDataOe_n,
    output logic      [15:0] userDataIn,
    output logic      [15:0] cfgWord,
    output logic             cfgWordValid,
    output logic             cfgWordWide,
    output logic             cfgBusy,
    output logic             userMode
);

    cpi_pkg::cpi_state_t  state_r;
    cpi_pkg::cpi_state_t  state_nxt;
    cpi_pkg::cpi_scheme_t scheme_r;
    logic                 apWide_r;
    logic [1:0]           strapCnt_r;
    logic [15:0]          dataSync;
    logic [3:0]           pinSync;
    logic                 ceSync_n;
    logic                 tglSync;
    logic                 tglPrev_r;
    logic                 newByte;
    logic                 isActive;
    logic                 isAs;
    logic                 clkRun;
    logic [7:0]           divCnt_r;
    logic                 clkPhase_r;
    logic                 riseTick;
    logic                 fallTick;
    logic [31:0]          cmdShift_r;
    logic                 cmdBit_r;
    logic [5:0]           cmdCnt_r;
    logic [7:0]           asShift_r;
    logic [2:0]           asCnt_r;

    cpi_link_if lnk ();

    // host-clocked capture for the two passive schemes
    cpi_link_capture u_cap (
        .linkClk (cfgClkIn),
        .rst     (rst),
        .fppMode (scheme_r == `CPI_SCH_FPP),
        .dataPin (dataIn[7:0]),
        .lnk     (lnk.cap)
    );

    // pins and the byte toggle enter the system domain through two flops
    cpi_sync #(.WIDTH(16)) u_dataSync (
        .clk (clk_sys),
        .rst (rst),
        .d   (dataIn),
        .q   (dataSync)
    );

    cpi_sync #(.WIDTH(4)) u_pinSync (
        .clk (clk_sys),
        .rst (rst),
        .d   ({chipEnable_n, apWide, schemeSel}),
        .q   (pinSync)
    );

    cpi_sync #(.WIDTH(1)) u_tglSync (
        .clk (clk_sys),
        .rst (rst),
        .d   (lnk.byteTgl),
        .q   (tglSync)
    );

    assign ceSync_n = pinSync[3];
    assign isActive = scheme_r[1];
    assign isAs     = (scheme_r == `CPI_SCH_AS);
    assign clkRun   = isActive &&
                      (state_r == cpi_pkg::ST_CMD ||
                       state_r == cpi_pkg::ST_RECV);
    assign riseTick = clkRun && !clkPhase_r &&
                      (divCnt_r == 8'(`CPI_CLK_HALF_CYC - 1));
    assign fallTick = clkRun && clkPhase_r &&
                      (divCnt_r == 8'(`CPI_CLK_HALF_CYC - 1));
    // byte from the host only counts while receiving in a passive scheme
    assign newByte  = (tglSync ^ tglPrev_r) && !isActive &&
                      (state_r == cpi_pkg::ST_RECV);

    // edge detect on the synchronised toggle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tglPrev_r <= 1'h0;
        end else begin
            tglPrev_r <= tglSync;
        end
    end

    // straps are latched after the synchronisers have settled
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            strapCnt_r <= 2'h0;
            scheme_r   <= `CPI_SCH_PS;
            apWide_r   <= 1'h0;
        end else if (state_r == cpi_pkg::ST_STRAP) begin
            strapCnt_r <= strapCnt_r + 2'h1;
            scheme_r   <= pinSync[1:0];
            apWide_r   <= pinSync[2];
        end
    end

    // loader sequence
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            cpi_pkg::ST_STRAP: begin
                if (strapCnt_r == `CPI_STRAP_WAIT) begin
                    state_nxt = cpi_pkg::ST_IDLE;
                end
            end
            cpi_pkg::ST_IDLE: begin
                if (!ceSync_n) begin
                    state_nxt = isAs ? cpi_pkg::ST_CMD : cpi_pkg::ST_RECV;
                end
            end
            cpi_pkg::ST_CMD: begin
                if (ceSync_n) begin
                    state_nxt = cpi_pkg::ST_IDLE;
                end else if (fallTick && cmdCnt_r == `CPI_AS_CMD_BITS)
                begin
                    state_nxt = cpi_pkg::ST_RECV;
                end
            end
            cpi_pkg::ST_RECV: begin
                if (ceSync_n) begin
                    state_nxt = cpi_pkg::ST_IDLE;
                end else if (cfgComplete) begin
                    state_nxt = cpi_pkg::ST_USER;
                end
            end
            cpi_pkg::ST_USER: begin
                state_nxt = cpi_pkg::ST_USER;
            end
            default: begin
                state_nxt = cpi_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r <= cpi_pkg::ST_STRAP;
        end else begin
            state_r <= state_nxt;
        end
    end

    // config clock divider for the active schemes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            divCnt_r   <= 8'h00;
            clkPhase_r <= `CPI_CLK_IDLE;
        end else if (!clkRun) begin
            divCnt_r   <= 8'h00;
            clkPhase_r <= `CPI_CLK_IDLE;
        end else if (divCnt_r == 8'(`CPI_CLK_HALF_CYC - 1)) begin
            divCnt_r   <= 8'h00;
            clkPhase_r <= ~clkPhase_r;
        end else begin
            divCnt_r   <= divCnt_r + 8'h01;
        end
    end

    // read request to the serial memory, changed on falling clock
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cmdShift_r <= 32'h00000000;
            cmdBit_r   <= `CPI_CMD_IDLE;
            cmdCnt_r   <= 6'h00;
        end else if (state_r == cpi_pkg::ST_IDLE && state_nxt ==
                     cpi_pkg::ST_CMD) begin
            cmdShift_r <= {`CPI_AS_READ_CMD, `CPI_AS_START_ADDR} << 1;
            cmdBit_r   <= 1'(`CPI_AS_READ_CMD >> 7);
            cmdCnt_r   <= 6'h00;
        end else if (state_r == cpi_pkg::ST_CMD) begin
            if (fallTick) begin
                cmdBit_r   <= cmdShift_r[31];
                cmdShift_r <= cmdShift_r << 1;
            end
            if (riseTick) begin
                cmdCnt_r <= cmdCnt_r + 6'h01;
            end
        end else if (state_r != cpi_pkg::ST_RECV) begin
            cmdBit_r <= `CPI_CMD_IDLE;
        end
    end

    // data collection: serial bits, parallel words, or host bytes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            asShift_r    <= 8'h00;
            asCnt_r      <= 3'h0;
            cfgWord      <= 16'h0000;
            cfgWordValid <= 1'h0;
            cfgWordWide  <= 1'h0;
        end else begin
            cfgWordValid <= 1'h0;
            if (state_r != cpi_pkg::ST_RECV) begin
                asCnt_r <= 3'h0;
            end else if (isAs && fallTick) begin    // value of last pin rise
                asShift_r <= {dataSync[0], asShift_r[7:1]};
                asCnt_r   <= asCnt_r + 3'h1;
                if (asCnt_r == 3'h7) begin
                    cfgWord      <= {8'h00, dataSync[0], asShift_r[7:1]};
                    cfgWordValid <= 1'h1;
                    cfgWordWide  <= 1'h0;
                end
            end else if (isActive && fallTick) begin
                cfgWord      <= apWide_r ? dataSync :
                                {8'h00, dataSync[7:0]};
                cfgWordValid <= 1'h1;
                cfgWordWide  <= apWide_r;
            end else if (newByte) begin
                cfgWord      <= {8'h00, lnk.byteHold};
                cfgWordValid <= 1'h1;
                cfgWordWide  <= 1'h0;
            end
        end
    end

    // status flags
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfgBusy  <= 1'h0;
            userMode <= 1'h0;
        end else begin
            cfgBusy  <= (state_nxt == cpi_pkg::ST_CMD) ||
                        (state_nxt == cpi_pkg::ST_RECV);
            userMode <= (state_nxt == cpi_pkg::ST_USER);
        end
    end

    // config clock pin drive
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfgClkOut  <= `CPI_CLK_IDLE;
            cfgClkOe_n <= 1'h1;
        end else if (!isActive || state_r == cpi_pkg::ST_STRAP) begin
            cfgClkOut  <= `CPI_CLK_IDLE;
            cfgClkOe_n <= 1'h1;
        end else if (state_r == cpi_pkg::ST_USER && userClkEn) begin
            cfgClkOut  <= userClkOut;
            cfgClkOe_n <= userClkOe_n;
        end else if (state_r == cpi_pkg::ST_USER) begin
            cfgClkOut  <= `CPI_CLK_IDLE;
            cfgClkOe_n <= 1'h0;
        end else begin
            cfgClkOut  <= clkPhase_r;
            cfgClkOe_n <= 1'h0;
        end
    end

    // pin values seen by user logic
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            userDataIn <= 16'h0000;
        end else begin
            userDataIn <= dataSync;
        end
    end

    // data pin drive, one slice per pin
    genvar i;
    for (i = 0; i < 16; i++) begin : g_pin
        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                dataOut[i]  <= 1'h0;
                dataOe_n[i] <= 1'h1;
            end else if (state_r == cpi_pkg::ST_USER) begin
                if (isAs && i == 0) begin
                    dataOut[i]  <= 1'h0;
                    dataOe_n[i] <= 1'h1;
                end else if (isAs && i == 1) begin
                    dataOut[i]  <= userDataOut[i];
                    dataOe_n[i] <= 1'h0;
                end else begin
                    dataOut[i]  <= userDataOut[i];
                    dataOe_n[i] <= userDataOe_n[i];
                end
            end else if (isAs && i == 1 &&
                         state_r != cpi_pkg::ST_STRAP) begin
                dataOut[i]  <= cmdBit_r;
                dataOe_n[i] <= 1'h0;
            end else begin
                dataOut[i]  <= 1'h0;
                dataOe_n[i] <= 1'h1;
            end
        end
    end

endmodule : cpi_config_pins

//--- sim/cpi_config_pins_asserts.sv
// checker of the configuration pin block ports
// assumes straps stay stable from reset onward
`timescale 1ns/1ns
`include "cpi_regs.svh"
module cpi_config_pins_asserts (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        cfgClkOut,
    input wire logic        cfgClkOe_n,
    input wire logic [15:0] dataOut,
    input wire logic [15:0] dataOe_n,
    input wire logic [1:0]  schemeSel,
    input wire logic        apWide,
    input wire logic        cfgComplete,
    input wire logic        userClkEn,
    input wire logic        userClkOut,
    input wire logic        userClkOe_n,
    input wire logic [15:0] userDataOut,
    input wire logic [15:0] userDataOe_n,
    input wire logic [15:0] cfgWord,
    input wire logic        cfgWordValid,
    input wire logic        cfgWordWide,
    input wire logic        cfgBusy,
    input wire logic        userMode
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    wire isAs = schemeSel == `CPI_SCH_AS;
    wire act  = schemeSel[1];

    // pin direction during configuration
    cfg_inputs_a: assert property (
        !userMode |-> dataOe_n[0] && (&dataOe_n[15:2])
            && (dataOe_n[1] || isAs))
        else $error("data pin driven in configuration");
    pas_clock_a: assert property (!act |-> cfgClkOe_n)
        else $error("passive clock pin driven");
    act_clock_a: assert property (act && cfgBusy |-> !cfgClkOe_n)
        else $error("active clock pin not driven");
    cmd_drive_a: assert property (isAs && cfgBusy |-> !dataOe_n[1])
        else $error("request line not driven");
    cmd_hold_a: assert property (
        isAs && cfgBusy && $rose(cfgClkOut) |-> $stable(dataOut[1]))
        else $error("request bit moved at rising clock");

    // driven clock shape and parking
    clk_rate_a: assert property (disable iff (rst || cfgComplete)
        $rose(cfgClkOut) && cfgBusy |=> cfgClkOut ##1 !cfgClkOut)
        else $error("clock half period wrong");
    clk_idle_a: assert property (
        act && !cfgBusy && !$past(cfgBusy) && !userMode |-> !cfgClkOut)
        else $error("clock runs while idle");
    clk_park_a: assert property (
        act && userMode && $past(userMode) && !userClkEn && !$past(userClkEn)
        |-> !cfgClkOut && !cfgClkOe_n)
        else $error("clock not parked low");
    clk_user_a: assert property (
        act && userMode && $past(userMode) && userClkEn && $past(userClkEn)
        |-> cfgClkOut == $past(userClkOut)
            && cfgClkOe_n == $past(userClkOe_n))
        else $error("clock pin ignores user");

    // user mode pins and words
    as_user_a: assert property (
        isAs && userMode && $past(userMode) |-> dataOe_n[0] && !dataOe_n[1]
            && dataOut[1] == $past(userDataOut[1]))
        else $error("serial active user pins wrong");
    usr_pins_a: assert property (
        !isAs && userMode && $past(userMode)
        |-> dataOut[1:0] == $past(userDataOut[1:0])
            && dataOe_n[1:0] == $past(userDataOe_n[1:0]))
        else $error("user data pins wrong");
    no_late_a: assert property (
        userMode && $past(userMode) |-> !cfgWordValid)
        else $error("word after configuration");
    word_wide_a: assert property (
        cfgWordValid |-> cfgWordWide == (schemeSel == `CPI_SCH_AP && apWide)
            && (cfgWordWide || cfgWord[15:8] == 8'h00))
        else $error("word width wrong");
endmodule : cpi_config_pins_asserts

bind cpi_config_pins cpi_config_pins_asserts chk (.*);

//--- sim/cpi_far_model.sv
// far side: passive host, serial memory and parallel flash
// assumes the bench resolves pins; mode is the strap code
`timescale 1ns/1ns
module cpi_far_model (
    input  wire logic       rst,
    input  wire logic       clkPin,
    input  wire logic       clkOe_n,
    input  wire logic       cmdPin,
    input  wire logic [1:0] mode,
    output logic            linkClk,
    output logic [15:0]     farData,
    output logic            cmdOk
);
    localparam logic [15:0] AS_STREAM = 16'hC35A;
    logic [31:0] cmd;
    logic [5:0]  rises;
    logic [3:0]  bitN;

    // memory takes request bits on rising clock, msb first
    always @(posedge clkPin or posedge rst) begin
        if (rst) begin
            cmd   <= 32'h0;
            rises <= 6'h0;
        end else if (!clkOe_n && rises < 6'h20) begin
            cmd   <= {cmd[30:0], cmdPin};
            rises <= rises + 6'h1;
        end
    end
    assign cmdOk = rises == 6'h20 && cmd == 32'h03000000;

    // memory and flash change data after falling clock
    always @(negedge clkPin or posedge rst) begin
        if (rst) begin
            bitN    <= 4'h0;
            farData <= (mode == 2'h3) ? 16'h12FE : 16'hFFFF;
        end else if (!clkOe_n && mode == 2'h3) begin
            farData <= farData + 16'h1;
        end else if (!clkOe_n && rises == 6'h20) begin
            farData[0] <= AS_STREAM[bitN];
            bitN       <= bitN + 4'h1;
        end
    end

    // host clock stands low outside frames
    initial linkClk = 1'b0;

    // one host clock, data held briefly past the rising edge
    task automatic pulse(input logic [15:0] d);
        farData = d;
        #8 linkClk = 1'b1;
        #4 farData = ~d;
        #11 linkClk = 1'b0;
        #7;
    endtask : pulse
endmodule : cpi_far_model

//--- sim/tb_config_pin_interface.sv
// bench of the configuration pin block: four schemes and user mode
// assumes the far side model of cpi_far_model.sv
`timescale 1ns/1ns
`include "cpi_regs.svh"
module tb_config_pin_interface;
    logic        clk_sys;
    logic        rst          = 1'b0;
    logic [1:0]  schemeSel    = 2'h0;
    logic        apWide       = 1'b0;
    logic        cfgComplete  = 1'b0;
    logic        userClkEn    = 1'b0;
    logic        userClkOut   = 1'b0;
    logic        userClkOe_n  = 1'b1;
    logic [15:0] userDataOut  = 16'h0;
    logic [15:0] userDataOe_n = 16'hFFFF;
    logic        chipEnable_n = 1'b0;
    logic        cfgClkOut, cfgClkOe_n, cfgWordValid, cfgWordWide;
    logic        cfgBusy, userMode, linkClk, cmdOk;
    logic [15:0] dataOut, dataOe_n, userDataIn, cfgWord, farData;
    wire  [15:0] dataIn   = (~dataOe_n & dataOut) | (dataOe_n & farData);
    wire         cfgClkIn = cfgClkOe_n ? linkClk : cfgClkOut;
    int          err_count = 0;
    int          samples_checked = 0;
    int          validCnt = 0;

    cpi_config_pins uut (.*);
    cpi_far_model far (.rst(rst), .clkPin(cfgClkOut), .clkOe_n(cfgClkOe_n),
        .cmdPin(dataOut[1]), .mode(schemeSel), .linkClk(linkClk),
        .farData(farData), .cmdOk(cmdOk));

    // system clock and word counter
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (cfgWordValid === 1'b1) validCnt++;

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check

    // reset with straps held from reset onward
    task automatic restart(input logic [1:0] sch, input logic wide);
        schemeSel   = sch;
        apWide      = wide;
        cfgComplete = 1'b0;
        userClkEn   = 1'b0;
        rst         = 1'b1;
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys) rst = 1'b0;
        repeat (20) @(negedge clk_sys);
    endtask : restart

    // wait for the next word under a bound
    task automatic nextWord;
        int i = 0;
        @(negedge clk_sys);
        while (cfgWordValid !== 1'b1 && i < 3000) begin
            @(negedge clk_sys);
            i++;
        end
        check("word valid", 16'h1, {15'h0, cfgWordValid});
    endtask : nextWord

    task automatic goUser;
        cfgComplete = 1'b1;
        repeat (4) @(negedge clk_sys);
        check("user mode", 16'h1, {15'h0, userMode});
        check("busy", 16'h0, {15'h0, cfgBusy});
    endtask : goUser

    // user values drive the data pins and return as levels
    task automatic userPins;
        userDataOut  = 16'h0002;
        userDataOe_n = 16'hFFFC;
        repeat (6) @(negedge clk_sys);
        check("pin oe", 16'hFFFC, dataOe_n);
        check("pin out", 16'h0002, dataOut);
        check("pin in", 16'h0002, {14'h0, userDataIn[1:0]});
    endtask : userPins

    task automatic psTest;
        logic [7:0] v = 8'hB4;
        int n;
        restart(`CPI_SCH_PS, 1'b0);
        fork
            for (int b = 0; b < 8; b++) far.pulse({15'h0, v[b]});
        join_none
        nextWord();
        check("ps word", 16'h00B4, cfgWord);
        goUser();
        userPins();
        check("ps clock oe", 16'h1, {15'h0, cfgClkOe_n});
        n = validCnt;
        for (int b = 0; b < 8; b++) far.pulse(16'h0001);
        repeat (10) @(negedge clk_sys);
        check("late words", 16'(n), 16'(validCnt));
        $display("passive serial test done");
    endtask : psTest

    task automatic fppTest;
        restart(`CPI_SCH_FPP, 1'b0);
        far.pulse(16'h0);
        far.pulse(16'h0);
        repeat (10) @(negedge clk_sys);
        fork
            begin
                far.pulse(16'h003C);
                #30 far.pulse(16'h00C3);
            end
        join_none
        nextWord();
        check("fpp word 1", 16'h003C, cfgWord);
        nextWord();
        check("fpp word 2", 16'h00C3, cfgWord);
        goUser();
        userPins();
        $display("fast passive test done");
    endtask : fppTest

    task automatic asTest;
        chipEnable_n = 1'b1;
        restart(`CPI_SCH_AS, 1'b0);
        check("as held", 16'h0, {15'h0, cfgBusy});
        chipEnable_n = 1'b0;
        nextWord();
        check("as request", 16'h1, {15'h0, cmdOk});
        check("as word 1", 16'h005A, cfgWord);
        nextWord();
        check("as word 2", 16'h00C3, cfgWord);
        goUser();
        check("as park", 16'h0, {14'h0, cfgClkOut, cfgClkOe_n});
        userDataOut  = 16'h0002;
        userDataOe_n = 16'h0000;
        userClkEn    = 1'b1;
        userClkOut   = 1'b1;
        userClkOe_n  = 1'b0;
        repeat (4) @(negedge clk_sys);
        check("as pin oe", 16'h1, {14'h0, dataOe_n[1:0]});
        check("as data1", 16'h1, {15'h0, dataOut[1]});
        check("as user clk", 16'h2, {14'h0, cfgClkOut, cfgClkOe_n});
        $display("active serial test done");
    endtask : asTest

    task automatic apTest(input logic wide);
        logic [15:0] prev;
        logic [15:0] exp;
        restart(`CPI_SCH_AP, wide);
        nextWord();
        prev = cfgWord;
        nextWord();
        exp = wide ? prev + 16'h1 : {8'h00, prev[7:0] + 8'h01};
        check("ap word", exp, cfgWord);
        check("ap wide", {15'h0, wide}, {15'h0, cfgWordWide});
        goUser();
        check("ap park", 16'h0, {14'h0, cfgClkOut, cfgClkOe_n});
        userPins();
        $display("active parallel test done");
    endtask : apTest

    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    // watchdog well beyond the expected run
    initial begin
        #200000;
        err_count++;
        conclude();
    end

    // main sequence
    initial begin
        psTest();
        fppTest();
        asTest();
        apTest(1'b0);
        apTest(1'b1);
        conclude();
    end
endmodule : tb_config_pin_interface
